//--- rtl/lps_top.sv
`timescale 1ns/1ns
`include "lps_map.svh"

// How it works
// - pattern resets constant torque; four codes
// - constant torque: voltage linear to base
// - variable torque: voltage square law
// - code 2: boost forward, zero reverse
// - code 3: zero forward, boost reverse
// - second input selects second torque boost
// - second input switches only the torque boost, shown on second_func_o
// - second input from terminal code 3
// - vector control disables load pattern
// - pattern writable only if group select zero
// - single high/middle/low selects its preset
// - presets limited to 0 to 400 Hz
// - speeds 4-15 from input combinations
// - 9999 means unselected; default for 4-15
// - speed 8 unset: extension alone uses low
// - multiple inputs, combination unset: low beats middle beats high
// - presets writable anytime; 4-15 only if group select zero
// - low/middle/high movable by codes 0,1,2
// - extension input only via code 8
// - jog, presets, terminal 4, terminal 2
// - presets only in operation modes 3, 4
// - remote function nonzero disables presets
module lps_top #(
    parameter int N_TERM = 7
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // contact terminals
    input wire logic [N_TERM-1:0] term_i,
    // drive state and other frequency sources
    input wire logic run_i,
    input wire logic reverse_i,
    input wire lps_pkg::lps_freq_t out_freq_i,
    input wire logic jog_active_i,
    input wire lps_pkg::lps_freq_t jog_freq_i,
    input wire logic ana4_valid_i,
    input wire lps_pkg::lps_freq_t ana4_freq_i,
    input wire lps_pkg::lps_freq_t ana2_freq_i,
    // commands
    output lps_pkg::lps_freq_t freq_cmd_o,
    output logic [15:0] volt_cmd_o,
    output logic [15:0] boost_o,
    output logic second_func_o,
    output logic preset_active_o,
    output logic [3:0] speed_sel_o
);
    import lps_pkg::*;

    lps_pattern_t pat_q;
    logic [1:0] vec_q;
    logic [2:0] opm_q;
    logic [1:0] pws_q;
    logic [1:0] rem_q;
    logic ugr_q;
    logic [15:0] boost1_q;
    logic [15:0] boost2_q;
    lps_freq_t base_f_q;
    logic [15:0] base_v_q;
    logic [4*N_TERM-1:0] term_sel_q;
    lps_freq_t preset_q [15];
    logic [N_TERM-1:0] term_meta;
    logic [N_TERM-1:0] term_sync;
    logic rh_s, rm_s, rl_s, rex_s, second_s;
    logic [3:0] next_speed;
    logic next_preset_en;
    lps_freq_t next_freq;
    logic [15:0] next_boost;
    logic [15:0] next_volt;
    lps_pattern_t eff_pat;
    logic wr, np_lock;
    logic [31:0] wdat, reg_val;
    logic [31:0] next_rdat;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // rank: low beats middle beats high
    function automatic logic [3:0] prio(input logic [2:0] hml);
        if (hml[0]) begin
            return 4'h3;
        end else if (hml[1]) begin
            return 4'h2;
        end else if (hml[2]) begin
            return 4'h1;
        end
        return 4'h0;
    endfunction

    function automatic logic f_ok(input lps_freq_t v, input logic allow_none);
        return (v <= `LPS_FREQ_MAX) || (allow_none && v == `LPS_FREQ_NONE);
    endfunction

    // terminal synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            term_meta <= '0;
            term_sync <= '0;
        end else begin
            term_meta <= term_i;
            term_sync <= term_meta;
        end
    end

    // function routing from terminal selectors
    always_comb begin
        rh_s = 1'b0;
        rm_s = 1'b0;
        rl_s = 1'b0;
        rex_s = 1'b0;
        second_s = 1'b0;
        for (int t = 0; t < N_TERM; t++) begin
            if (term_sync[t]) begin
                case (term_sel_q[4*t +: 4])
                    `LPS_FN_LOW: rl_s = 1'b1;
                    `LPS_FN_MID: rm_s = 1'b1;
                    `LPS_FN_HIGH: rh_s = 1'b1;
                    `LPS_FN_SECOND: second_s = 1'b1;
                    `LPS_FN_EXT: rex_s = 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // bus access
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign np_lock = (pws_q == 2'h1) || (pws_q == 2'h0 && run_i);

    // stored word at the address; writes merge byte lanes into it
    always_comb begin
        reg_val = '0;
        case (wb_adr_i)
            `LPS_OFF_CTRL: reg_val = {11'h000, ugr_q, 2'h0, rem_q, 2'h0, pws_q, 1'b0, opm_q,
                                      2'h0, vec_q, 2'h0, pat_q};
            `LPS_OFF_BOOST: reg_val = {boost2_q, boost1_q};
            `LPS_OFF_BASE: reg_val = {base_v_q, base_f_q};
            `LPS_OFF_TERM: reg_val = {{(32 - 4 * N_TERM){1'b0}}, term_sel_q};
            default: begin
                for (int i = 0; i < 15; i++) begin
                    if (wb_adr_i == `LPS_OFF_PRESET + 8'(4 * i)) begin
                        reg_val = {16'h0000, preset_q[i]};
                    end
                end
            end
        endcase
        wdat = merge(reg_val, wb_dat_i, wb_sel_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pat_q <= LPS_CONST;
            vec_q <= '0;
            opm_q <= '0;
            pws_q <= '0;
            rem_q <= '0;
            ugr_q <= 1'b0;
        end else if (wr && wb_adr_i == `LPS_OFF_CTRL) begin
            if (!ugr_q && !np_lock) begin
                pat_q <= lps_pattern_t'(wdat[`LPS_CTRL_PAT +: 2]);
            end
            vec_q <= wdat[`LPS_CTRL_VEC +: 2];
            opm_q <= wdat[`LPS_CTRL_OPM +: 3];
            pws_q <= wdat[`LPS_CTRL_PWS +: 2];
            rem_q <= wdat[`LPS_CTRL_REM +: 2];
            ugr_q <= wdat[`LPS_CTRL_UGR];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boost1_q <= `LPS_RST_BOOST;
            boost2_q <= `LPS_RST_BOOST;
            base_f_q <= `LPS_RST_BASE_F;
            base_v_q <= `LPS_RST_BASE_V;
            term_sel_q <= `LPS_RST_TERM;
        end else if (wr && !np_lock) begin
            if (wb_adr_i == `LPS_OFF_BOOST) begin
                boost1_q <= wdat[15:0];
                boost2_q <= wdat[31:16];
            end
            if (wb_adr_i == `LPS_OFF_BASE && !ugr_q) begin
                base_f_q <= wdat[15:0];
                base_v_q <= wdat[31:16];
            end
            if (wb_adr_i == `LPS_OFF_TERM) begin
                term_sel_q <= wdat[4*N_TERM-1:0];
            end
        end
    end

    // presets ignore the write-protect selection and run state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            preset_q[0] <= `LPS_RST_HIGH;
            preset_q[1] <= `LPS_RST_MID;
            preset_q[2] <= `LPS_RST_LOW;
            for (int i = 3; i < 15; i++) begin
                preset_q[i] <= `LPS_FREQ_NONE;
            end
        end else begin
            for (int i = 0; i < 15; i++) begin
                if (wr && wb_adr_i == `LPS_OFF_PRESET + 8'(4 * i)
                    && (i < 3 || !ugr_q) && f_ok(wdat[15:0], i >= 3)) begin
                    preset_q[i] <= wdat[15:0];
                end
            end
        end
    end

    always_comb begin
        case (wb_adr_i)
            `LPS_OFF_STAT: next_rdat = {9'h000, second_func_o, preset_active_o, 1'b0,
                                        speed_sel_o, freq_cmd_o};
            `LPS_OFF_VOLT: next_rdat = {boost_o, volt_cmd_o};
            default: next_rdat = reg_val;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= next_rdat;
        end
    end

    // combination decode, skipping unset slots
    always_comb begin
        logic [2:0] hml;
        logic [3:0] s;
        hml = {rh_s, rm_s, rl_s};
        s = 4'h0;
        next_speed = prio(hml);
        if (rex_s) begin
            s = {1'b1, hml};
            if (preset_q[s - 4'h1] != `LPS_FREQ_NONE) begin
                next_speed = s;
            end else if (hml == 3'h0) begin
                next_speed = 4'h3;
            end
        end else if (hml == 3'h3 || hml[2] && hml != 3'h4) begin
            s = (hml == 3'h3) ? 4'h4 : {1'b0, hml};
            if (preset_q[s - 4'h1] != `LPS_FREQ_NONE) begin
                next_speed = s;
            end
        end
        next_preset_en = (opm_q == `LPS_OPM_EXT || opm_q == `LPS_OPM_COMB)
                         && rem_q == 2'h0 && next_speed != 4'h0;
    end

    always_comb begin
        if (jog_active_i) begin
            next_freq = jog_freq_i;
        end else if (next_preset_en) begin
            next_freq = preset_q[next_speed - 4'h1];
        end else if (ana4_valid_i) begin
            next_freq = ana4_freq_i;
        end else begin
            next_freq = ana2_freq_i;
        end
    end

    // voltage curve and effective boost
    always_comb begin
        logic [31:0] fc, fb;
        eff_pat = (vec_q != 2'h0) ? LPS_CONST : pat_q;
        fb = {16'h0000, base_f_q};
        fc = (out_freq_i > base_f_q) ? fb : {16'h0000, out_freq_i};
        next_boost = second_s ? boost2_q : boost1_q;
        if ((eff_pat == LPS_LIFT_FWD && reverse_i)
            || (eff_pat == LPS_LIFT_REV && !reverse_i)) begin
            next_boost = 16'h0000;
        end
        if (fb == 32'h0) begin
            next_volt = base_v_q;
        end else if (eff_pat == LPS_VAR) begin
            next_volt = 16'((({32'h0, fc * fc}) * base_v_q) / (fb * fb));
        end else begin
            next_volt = 16'((fc * base_v_q) / fb);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_cmd_o <= '0;
            volt_cmd_o <= '0;
            boost_o <= '0;
            second_func_o <= 1'b0;
            preset_active_o <= 1'b0;
            speed_sel_o <= '0;
        end else begin
            freq_cmd_o <= next_freq;
            volt_cmd_o <= next_volt;
            boost_o <= next_boost;
            second_func_o <= second_s;
            preset_active_o <= next_preset_en && !jog_active_i;
            speed_sel_o <= next_speed;
        end
    end

    AST_PAT_RESET: assert property (@(posedge clk_i) $past(rst_i) |-> pat_q == LPS_CONST)
        else $error("pattern not constant torque after reset");
    AST_REV_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (pat_q == LPS_LIFT_FWD && vec_q == 2'h0 && reverse_i) |=> boost_o == 16'h0000)
        else $error("boost not zero in reverse");
    AST_FWD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (pat_q == LPS_LIFT_REV && vec_q == 2'h0 && !reverse_i) |=> boost_o == 16'h0000)
        else $error("boost not zero in forward");
    AST_SECOND_BOOST: assert property (@(posedge clk_i) disable iff (rst_i)
        (second_s && pat_q == LPS_CONST) |=> boost_o == $past(boost2_q))
        else $error("second boost not used");
    AST_UG_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        ugr_q |=> $stable(pat_q))
        else $error("pattern changed while group locked");
    AST_HIGH_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
        preset_q[0] <= `LPS_FREQ_MAX)
        else $error("high preset out of range");
    AST_SPEED8: assert property (@(posedge clk_i) disable iff (rst_i)
        (rex_s && !rh_s && !rm_s && !rl_s && preset_q[7] == `LPS_FREQ_NONE)
        |=> speed_sel_o == 4'h3)
        else $error("unset speed 8 did not fall back to low");
    AST_LOW_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rex_s && rl_s && rm_s && !rh_s && preset_q[3] == `LPS_FREQ_NONE)
        |=> speed_sel_o == 4'h3)
        else $error("low input did not win");
    AST_JOG_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
        jog_active_i |=> freq_cmd_o == $past(jog_freq_i) && !preset_active_o)
        else $error("jog not first");
    AST_MODE_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
        (opm_q != `LPS_OPM_EXT && opm_q != `LPS_OPM_COMB) |=> !preset_active_o)
        else $error("preset active outside modes 3 and 4");
    AST_REMOTE: assert property (@(posedge clk_i) disable iff (rst_i)
        rem_q != 2'h0 |=> !preset_active_o)
        else $error("preset active with remote function");
endmodule

//--- include/lps_map.svh
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH
// byte offsets
`define LPS_OFF_CTRL 8'h00
`define LPS_OFF_BOOST 8'h04
`define LPS_OFF_BASE 8'h08
`define LPS_OFF_TERM 8'h0c
`define LPS_OFF_STAT 8'h10
`define LPS_OFF_VOLT 8'h14
`define LPS_OFF_PRESET 8'h40
// ctrl fields
`define LPS_CTRL_PAT 0
`define LPS_CTRL_VEC 4
`define LPS_CTRL_OPM 8
`define LPS_CTRL_PWS 12
`define LPS_CTRL_REM 16
`define LPS_CTRL_UGR 20
// reset values, frequency unit 0.1 Hz
`define LPS_RST_HIGH 16'h01f4
`define LPS_RST_MID 16'h012c
`define LPS_RST_LOW 16'h0064
`define LPS_FREQ_NONE 16'h270f
`define LPS_FREQ_MAX 16'h0fa0
`define LPS_RST_BASE_F 16'h01f4
`define LPS_RST_BASE_V 16'h0190
`define LPS_RST_BOOST 16'h0032
`define LPS_RST_TERM 28'hff83210
// terminal function codes
`define LPS_FN_LOW 4'h0
`define LPS_FN_MID 4'h1
`define LPS_FN_HIGH 4'h2
`define LPS_FN_SECOND 4'h3
`define LPS_FN_EXT 4'h8
// operation modes enabling presets
`define LPS_OPM_EXT 3'h3
`define LPS_OPM_COMB 3'h4
`endif

//--- include/lps_pkg.sv
package lps_pkg;
    typedef enum logic [1:0] {
        LPS_CONST,
        LPS_VAR,
        LPS_LIFT_FWD,
        LPS_LIFT_REV
    } lps_pattern_t;
    typedef logic [15:0] lps_freq_t;
endpackage

//--- testbench/lps_contacts.sv
`timescale 1ns/1ns
// contact bank: a pressed contact reaches its terminal one edge later
module lps_contacts (
    // clock
    input wire logic clk_i,
    // operator side
    input wire logic [6:0] press_i,
    // terminal side
    output logic [6:0] term_o
);
    always_ff @(posedge clk_i) begin
        term_o <= press_i;
    end
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`include "lps_map.svh"
module tb_top;
    import lps_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic ack;
    logic second_func;
    logic preset_active;
    logic [6:0] press = 7'h00;
    logic [6:0] term;
    logic run = 1'b0;
    logic rev = 1'b0;
    logic jog = 1'b0;
    lps_freq_t out_freq = 16'h0000;
    lps_freq_t freq_cmd;
    logic [15:0] volt;
    logic [15:0] boost;
    logic [3:0] speed;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    always #4 clk_i = ~clk_i;

    lps_contacts u_contacts (.clk_i(clk_i), .press_i(press), .term_o(term));

    lps_top u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .term_i(term), .run_i(run), .reverse_i(rev), .out_freq_i(out_freq),
        .jog_active_i(jog), .jog_freq_i(16'h0032), .ana4_valid_i(1'b0),
        .ana4_freq_i(16'h0000), .ana2_freq_i(16'h0123), .freq_cmd_o(freq_cmd),
        .volt_cmd_o(volt), .boost_o(boost), .second_func_o(second_func),
        .preset_active_o(preset_active), .speed_sel_o(speed)
    );

    task automatic complete_run;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // bus work and settling are far below this ceiling
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic settle;
        repeat (6) @(posedge clk_i);
    endtask

    // classic single cycle, held until ack is seen at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        settle;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic setin(input logic r, input logic v, input logic j);
        @(posedge clk_i);
        run <= r;
        rev <= v;
        jog <= j;
        settle;
    endtask

    task automatic sel(input logic [6:0] v, input lps_freq_t f, input logic act);
        @(posedge clk_i);
        press <= v;
        settle;
        chk(freq_cmd, f);
        chk(preset_active, act);
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`LPS_OFF_CTRL, 32'h0);
        rd(`LPS_OFF_TERM, 32'h0ff83210);
        for (int i = 0; i < 15; i++) begin
            rd(8'h40 + 8'(4 * i), i == 0 ? 32'h1f4 : i == 1 ? 32'h12c : i == 2 ? 32'h64 : 32'h270f);
        end
        rd(8'h20, 32'h0);
        wr(`LPS_OFF_CTRL, 32'h300);
        sel(7'h04, 16'h01f4, 1'b1);
        chk(speed, 4'h1);
        sel(7'h02, 16'h012c, 1'b1);
        chk(speed, 4'h2);
        sel(7'h01, 16'h0064, 1'b1);
        chk(speed, 4'h3);
        sel(7'h06, 16'h012c, 1'b1);
        sel(7'h07, 16'h0064, 1'b1);
        sel(7'h10, 16'h0064, 1'b1);
        setin(1'b1, 1'b0, 1'b0);
        wr(8'h4c, 32'h100);
        setin(1'b0, 1'b0, 1'b0);
        rd(8'h4c, 32'h100);
        sel(7'h03, 16'h0100, 1'b1);
        chk(speed, 4'h4);
        wr(8'h40, 32'hfa1);
        rd(8'h40, 32'h1f4);
        wr(8'h40, 32'hfa0);
        rd(8'h40, 32'hfa0);
        wr(8'h40, 32'h1f4);
        wr(`LPS_OFF_CTRL, 32'h0);
        sel(7'h04, 16'h0123, 1'b0);
        wr(`LPS_OFF_CTRL, 32'h10300);
        sel(7'h04, 16'h0123, 1'b0);
        wr(`LPS_OFF_CTRL, 32'h300);
        setin(1'b0, 1'b0, 1'b1);
        chk(freq_cmd, 16'h0032);
        setin(1'b0, 1'b0, 1'b0);
        wr(`LPS_OFF_BOOST, 32'h00640032);
        sel(7'h00, 16'h0123, 1'b0);
        chk(boost, 16'h0032);
        sel(7'h08, 16'h0123, 1'b0);
        chk(second_func, 1'b1);
        chk(boost, 16'h0064);
        sel(7'h00, 16'h0123, 1'b0);
        chk(second_func, 1'b0);
        wr(`LPS_OFF_CTRL, 32'h302);
        setin(1'b0, 1'b1, 1'b0);
        chk(boost, 16'h0000);
        setin(1'b0, 1'b0, 1'b0);
        chk(boost, 16'h0032);
        wr(`LPS_OFF_CTRL, 32'h303);
        chk(boost, 16'h0000);
        setin(1'b0, 1'b1, 1'b0);
        chk(boost, 16'h0032);
        setin(1'b0, 1'b0, 1'b0);
        wr(`LPS_OFF_CTRL, 32'h313);
        chk(boost, 16'h0032);
        out_freq <= 16'h00fa;
        wr(`LPS_OFF_CTRL, 32'h300);
        chk(volt, 16'h00c8);
        wr(`LPS_OFF_CTRL, 32'h301);
        chk(volt, 16'h0064);
        wr(`LPS_OFF_CTRL, 32'h311);
        chk(volt, 16'h00c8);
        out_freq <= 16'h03e8;
        wr(`LPS_OFF_CTRL, 32'h301);
        chk(volt, 16'h0190);
        rd(`LPS_OFF_VOLT, 32'h00320190);
        wr(`LPS_OFF_CTRL, 32'h100300);
        wr(`LPS_OFF_CTRL, 32'h100301);
        rd(`LPS_OFF_CTRL, 32'h100300);
        wr(8'h50, 32'h200);
        rd(8'h50, 32'h270f);
        wr(`LPS_OFF_CTRL, 32'h300);
        wr(`LPS_OFF_TERM, 32'h028f3f10);
        sel(7'h40, 16'h01f4, 1'b1);
        rd(`LPS_OFF_STAT, 32'h002101f4);
        sel(7'h04, 16'h0123, 1'b0);
        sel(7'h20, 16'h0064, 1'b1);
        sel(7'h10, 16'h0123, 1'b0);
        complete_run;
    end
endmodule
